// file: cbt_checker.sv
// Purpose: port checks for command bus training
// Assumes: one clock, synchronous reset
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
module cbt_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic mode_write_valid,
  input wire logic [5:0] mode_write_addr,
  input wire logic [7:0] mode_write_data,
  input wire logic [5:0] ca_in,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe,
  input wire logic dqs_upper_oe,
  input wire logic mask_upper_oe,
  input wire logic setpoint_operating_bank,
  input wire logic setpoint_write_bank,
  input wire logic training_active,
  input wire logic normal_ready
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_upper_off: assert property (!dqs_upper_oe && !mask_upper_oe)
    else $error("upper strobe or mask driven");
  chk_oe_window: assert property (dq_oe == ($past(training_active) ? 16'h3f00 : 16'h0000))
    else $error("feedback enables wrong");
  chk_ca_echo: assert property ($past(ca_in, 3) == ca_in && $past(ca_in, 2) == ca_in
    && $past(ca_in) == ca_in |-> dq_out == {2'b00, ca_in, 8'h00}) else $error("ca echo wrong");
  chk_bank_flip: assert property ($rose(training_active)
    |-> setpoint_operating_bank != $past(setpoint_operating_bank)) else $error("bank not flipped");
  chk_no_arm: assert property (normal_ready |=> !training_active)
    else $error("training without enable");
  chk_ready_off: assert property (training_active |-> !normal_ready)
    else $error("ready during training");
  chk_exit_ready: assert property (mode_write_valid && mode_write_addr == 6'h0d
    && !mode_write_data[0] && !normal_ready |=> !normal_ready ##[1:6] normal_ready)
    else $error("exit recovery wrong");
  chk_wr_bank: assert property (mode_write_valid && mode_write_addr == 6'h0d
    |-> ##2 setpoint_write_bank == $past(mode_write_data[6], 2)) else $error("write bank wrong");
endmodule
bind cbt_command_bus_training cbt_checker u_chk (.sys_clk, .srst, .mode_write_valid,
  .mode_write_addr, .mode_write_data, .ca_in, .dq_out, .dq_oe, .dqs_upper_oe, .mask_upper_oe,
  .setpoint_operating_bank, .setpoint_write_bank, .training_active, .normal_ready);
`default_nettype wire

// file: cbt_command_bus_training.v
// Purpose: device-side command bus training logic of a low-power DRAM die
// Assumes: mode writes arrive decoded as a one-cycle strobe with address and data
// Notes: pins are sampled through two flops; the strobe edge is detected after sync
`timescale 1ns/1ps
`include "cbt_defines.vh"
`default_nettype none

module cbt_command_bus_training (
  input wire sys_clk,
  input wire srst,
  // decoded mode-register write from the command decoder
  input wire mode_write_valid,
  input wire [5:0] mode_write_addr,
  input wire [7:0] mode_write_data,
  // pins
  input wire cke,
  input wire [5:0] ca_in,
  input wire dqs_lower,
  input wire [15:0] dq_in,
  input wire mask_lower_in,
  // data pad drive
  output reg [15:0] dq_out,
  output reg [15:0] dq_oe,
  output reg dqs_upper_oe,
  output reg mask_upper_oe,
  // state visible to the rest of the die
  output reg setpoint_operating_bank,
  output reg setpoint_write_bank,
  output reg training_active,
  output reg [6:0] ca_reference,
  output reg normal_ready
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam [5:0] CONTROL_MODE_ADDR = `CBT_CONTROL_MODE_ADDR;
  localparam [5:0] CA_REF_MODE_ADDR = `CBT_CA_REF_MODE_ADDR;
  // cycle counts as plain integers, then cut to the counter width
  localparam integer ENTRY_CYC_INT = `CBT_ENTRY_DELAY_CYC;
  localparam integer RECOVER_CYC_INT = `CBT_MODE_RECOVERY_CYC;
  // entry count loaded one short: the cycle that reaches zero already accepts
  localparam [3:0] ENTRY_LOAD = ENTRY_CYC_INT[3:0] - 4'h1;
  localparam [3:0] RECOVER_CYC = RECOVER_CYC_INT[3:0];
  // sequencer states
  localparam [1:0] ST_NORMAL = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_TRAIN = 2'h2;
  localparam [1:0] ST_RECOVER = 2'h3;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire cke_s2;
  wire dqs_s2;
  wire [6:0] dq_s2;
  wire [5:0] ca_s2;
  reg cke_prev;
  reg dqs_prev;

  // cke idles high, so its flops reset high and no false fall follows reset
  cbt_pin_sync #(
    .WIDTH(1),
    .IDLE(1'h1)
  ) u_sync_cke (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(cke),
    .synced(cke_s2)
  );

  // lower strobe, both edges are used later
  cbt_pin_sync #(
    .WIDTH(1),
    .IDLE(1'h0)
  ) u_sync_dqs (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(dqs_lower),
    .synced(dqs_s2)
  );

  // only data bits six..zero; bit seven and lower mask never sampled
  cbt_pin_sync #(
    .WIDTH(7),
    .IDLE(7'h00)
  ) u_sync_dq (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(dq_in[6:0]),
    .synced(dq_s2)
  );

  // command-address levels for the feedback path
  cbt_pin_sync #(
    .WIDTH(6),
    .IDLE(6'h00)
  ) u_sync_ca (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(ca_in),
    .synced(ca_s2)
  );

  // previous synced levels for edge detection, reset to idle levels
  always @(posedge sys_clk) begin
    if (srst) begin
      cke_prev <= 1'h1;
      dqs_prev <= 1'h0;
    end else begin
      cke_prev <= cke_s2;
      dqs_prev <= dqs_s2;
    end
  end

  wire cke_fall = cke_prev & ~cke_s2;
  wire cke_rise = ~cke_prev & cke_s2;
  wire dqs_edge = dqs_prev ^ dqs_s2;

  // ----------------------------------------------------------------
  // mode registers and training state
  // ----------------------------------------------------------------
  reg [7:0] control_mode_register;
  reg [6:0] ca_reference_mode_register;
  reg [1:0] state;
  reg [3:0] wait_count;
  reg entry_open;
  reg saved_bank;

  wire ctrl_write = mode_write_valid && (mode_write_addr == CONTROL_MODE_ADDR);
  wire ref_write = mode_write_valid && (mode_write_addr == CA_REF_MODE_ADDR);
  wire train_en = control_mode_register[`CBT_CTRL_TRAIN_EN_BIT];

  // control and reference mode registers
  always @(posedge sys_clk) begin
    if (srst) begin
      control_mode_register <= `CBT_CTRL_RESET; // bank zero at power-up
      ca_reference_mode_register <= `CBT_CAREF_RESET;
    end else begin
      if (ctrl_write) begin
        control_mode_register <= mode_write_data;
      end
      if (ref_write) begin
        // trained values arrive only by explicit write
        ca_reference_mode_register <= mode_write_data[6:0];
      end
    end
  end

  // training sequencer
  always @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_NORMAL;
      wait_count <= 4'h0;
      entry_open <= 1'h0;
      saved_bank <= 1'h0;
      setpoint_operating_bank <= 1'h0;
      training_active <= 1'h0;
      ca_reference <= `CBT_CAREF_RESET;
      normal_ready <= 1'h1;
    end else begin
      case (state)
        // normal: bank and reference follow the mode registers
        ST_NORMAL: begin
          setpoint_operating_bank <= control_mode_register[`CBT_CTRL_OP_BANK_BIT];
          ca_reference <= ca_reference_mode_register;
          if (train_en) begin
            state <= ST_ARMED;
            normal_ready <= 1'h0;
          end
        end
        // armed: enable written, waiting for cke to fall
        ST_ARMED: begin
          if (!train_en) begin
            state <= ST_NORMAL;
            normal_ready <= 1'h1;
          end else if (cke_fall) begin
            // a fall needs cke high first, from idle or self refresh
            saved_bank <= setpoint_operating_bank;
            setpoint_operating_bank <= ~setpoint_operating_bank;
            training_active <= 1'h1;
            entry_open <= 1'h0;
            wait_count <= ENTRY_LOAD;
            state <= ST_TRAIN;
          end
        end
        // train: strobe captures open once the entry delay has run
        ST_TRAIN: begin
          if (wait_count != 4'h0) begin
            wait_count <= wait_count - 4'h1;
            if (wait_count == 4'h1) begin
              entry_open <= 1'h1;
            end
          end else begin
            entry_open <= 1'h1;
          end
          // every strobe edge once entry is open overwrites the reference, unless cke rises in the same cycle
          if (entry_open && dqs_edge) begin
            ca_reference <= dq_s2; // range bit six, level bits five..zero
          end
          if (cke_rise) begin
            // restore prior bank; trained value dropped
            setpoint_operating_bank <= saved_bank;
            ca_reference <= ca_reference_mode_register;
            training_active <= 1'h0;
            entry_open <= 1'h0;
            state <= ST_RECOVER;
            wait_count <= 4'h0;
          end
        end
        // recover: wait for the exit write, then the recovery time
        ST_RECOVER: begin
          if (wait_count != 4'h0) begin
            wait_count <= wait_count - 4'h1;
            if (wait_count == 4'h1) begin
              normal_ready <= 1'h1;
              state <= ST_NORMAL;
            end
          end else if (!train_en) begin
            wait_count <= RECOVER_CYC;
          end
        end
        default: begin
          state <= ST_NORMAL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  // feedback of ca onto dq13..8, others undriven in training
  always @(posedge sys_clk) begin
    if (srst) begin
      dq_out <= 16'h0000;
      dq_oe <= 16'h0000;
      dqs_upper_oe <= 1'b0;
      mask_upper_oe <= 1'b0;
      setpoint_write_bank <= 1'b0;
    end else begin
      setpoint_write_bank <= control_mode_register[`CBT_CTRL_WR_BANK_BIT];
      dq_out <= {2'b00, ca_s2, 8'h00}; // bit for bit
      dq_oe <= training_active ? `CBT_FEEDBACK_OE : 16'h0000;
      dqs_upper_oe <= 1'b0;
      mask_upper_oe <= 1'b0;
    end
  end

endmodule

// ----------------------------------------------------------------
// two-flop synchroniser for pin inputs
// ----------------------------------------------------------------
// only the second flop is read outside; the first may go metastable
module cbt_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] IDLE = {WIDTH{1'h0}}
) (
  input wire sys_clk,
  input wire srst,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] synced
);

  reg [WIDTH-1:0] meta;

  // reset to the pin's idle level so no false edge follows reset
  always @(posedge sys_clk) begin
    if (srst) begin
      meta <= IDLE;
      synced <= IDLE;
    end else begin
      meta <= pin;
      synced <= meta;
    end
  end

endmodule
`default_nettype wire

// file: cbt_command_bus_training_bench.sv
// Purpose: bench for command bus training
// Assumes: 40 MHz clock
// Notes: host model drives all pins
`timescale 1ns/1ps
`default_nettype none
module cbt_command_bus_training_bench;
  logic sys_clk, srst, mwv, cke, dqs, mlow, wbank, obank, tact, rdy, dqsu, masku;
  logic [5:0] mwa, ca;
  logic [7:0] mwd;
  logic [15:0] dqi, dq_out, dq_oe;
  logic [6:0] ca_reference;
  integer failures = 0;
  integer num_checks = 0;
  integer cycles = 0;
  cbt_host_model host (.sys_clk(sys_clk), .mode_write_valid(mwv), .mode_write_addr(mwa),
    .mode_write_data(mwd), .cke(cke), .ca_in(ca), .dqs_lower(dqs), .dq_in(dqi),
    .mask_lower_in(mlow));
  cbt_command_bus_training DUT (.sys_clk(sys_clk), .srst(srst), .mode_write_valid(mwv),
    .mode_write_addr(mwa), .mode_write_data(mwd), .cke(cke), .ca_in(ca), .dqs_lower(dqs),
    .dq_in(dqi), .mask_lower_in(mlow), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_upper_oe(dqsu),
    .mask_upper_oe(masku), .setpoint_operating_bank(obank), .setpoint_write_bank(wbank),
    .training_active(tact), .ca_reference(ca_reference), .normal_ready(rdy));
  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    #1;
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cke low without the enable bit is ignored
  task automatic t_refuse();
    host.pins(1'b0, 6'h00);
    repeat (8) @(posedge sys_clk);
    check("no entry", tact, 1'b0);
    host.pins(1'b1, 6'h00);
  endtask
  // one full entry, sweep, exit and write-back with counted waits
  task automatic t_train(input logic b);
    integer n;
    logic [6:0] keep;
    keep = ca_reference;
    host.mwr(6'h0d, {b, 1'b1, 5'h00, 1'b1});
    repeat (4) @(posedge sys_clk);
    check("write bank", wbank, 1'b1);
    host.pins(1'b0, 6'h00);
    for (n = 0; n < 20 && tact !== 1'b1; n++) @(posedge sys_clk);
    #2 check("alt bank", obank, !b);
    host.strobe(7'h11, 1); // single edge, well inside the entry delay
    repeat (4) @(posedge sys_clk);
    check("early strobe", ca_reference, keep);
    host.strobe(7'h2a, 4);
    repeat (10) @(posedge sys_clk);
    check("ref code", ca_reference, 7'h2a);
    host.strobe(7'h55, 4);
    repeat (10) @(posedge sys_clk);
    check("ref overwrite", ca_reference, 7'h55);
    check("feedback oe", dq_oe, 16'h3f00);
    for (n = 0; n < 6; n++) begin
      host.pins(1'b0, 6'h01 << n);
      repeat (4) @(posedge sys_clk);
      check("ca echo", dq_out, 16'h0100 << n);
    end
    host.pins(1'b1, 6'h00);
    repeat (10) @(posedge sys_clk);
    check("bank back", obank, b);
    check("ref not kept", ca_reference, keep);
    host.mwr(6'h0d, {b, 1'b1, 6'h00});
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge sys_clk);
    check("ready", rdy, 1'b1);
    host.mwr(6'h0c, 8'h33);
    repeat (3) @(posedge sys_clk);
    check("write back", ca_reference, 7'h33);
  endtask
  initial begin
    srst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 srst = 1'b0;
    check("reset bank", obank, 1'b0);
    check("reset ref", ca_reference, 7'h4d);
    check("reset ready", rdy, 1'b1);
    t_refuse();
    t_train(1'b0); // first pass stands for the terminating rank
    t_train(1'b1); // second pass from the other operating bank
    print_verdict();
  end
endmodule
`default_nettype wire

// file: cbt_defines.vh
// Purpose: constants for the command bus training block
// Assumes: 40 MHz sys_clk, 25 ns period
// Notes: times are in ns; cycle counts are derived from them
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH
`define CBT_CLK_PERIOD_NS 25
// control mode register fields
`define CBT_CTRL_TRAIN_EN_BIT 0
`define CBT_CTRL_WR_BANK_BIT 6
`define CBT_CTRL_OP_BANK_BIT 7
`define CBT_CTRL_RESET 8'h00
// ca reference mode register reset value and fields
`define CBT_CAREF_RESET 7'h4d
`define CBT_CAREF_RANGE_BIT 6
// timing in ns
`define CBT_ENTRY_DELAY_NS 250
`define CBT_MODE_RECOVERY_NS 100
// entry delay is a least time: round up
`define CBT_ENTRY_DELAY_CYC ((`CBT_ENTRY_DELAY_NS + `CBT_CLK_PERIOD_NS - 1) / `CBT_CLK_PERIOD_NS)
`define CBT_MODE_RECOVERY_CYC ((`CBT_MODE_RECOVERY_NS + `CBT_CLK_PERIOD_NS - 1) / `CBT_CLK_PERIOD_NS)
// mode register addresses
`define CBT_CONTROL_MODE_ADDR 6'h0d
`define CBT_CA_REF_MODE_ADDR 6'h0c
// data pins driven with command-address feedback in training
`define CBT_FEEDBACK_OE 16'h3f00
`endif

// file: cbt_host_model.sv
// Purpose: memory controller side of training
// Assumes: tasks drive 2 ns after the rising edge; ignored pins change on the edge itself
// Notes: ignored pins toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module cbt_host_model (
  input wire logic sys_clk,
  output logic mode_write_valid,
  output logic [5:0] mode_write_addr,
  output logic [7:0] mode_write_data,
  output logic cke,
  output logic [5:0] ca_in,
  output logic dqs_lower,
  output logic [15:0] dq_in,
  output logic mask_lower_in
);
  // idle with cke high before any entry
  initial begin
    {mode_write_valid, mode_write_addr, mode_write_data} = 15'h0000;
    {cke, ca_in, dqs_lower, dq_in, mask_lower_in} = 25'h1000000;
  end
  // don't-care pins never hold a value
  always @(posedge sys_clk) begin
    dq_in[15:7] <= ~dq_in[15:7];
    mask_lower_in <= ~mask_lower_in;
  end
  // one decoded mode write
  task automatic mwr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2 {mode_write_addr, mode_write_data, mode_write_valid} = {a, d, 1'b1};
    @(posedge sys_clk);
    #2 {mode_write_data, mode_write_valid} = {~d, 1'b0};
  endtask
  // cke and ca levels, clock keeps running
  task automatic pins(input logic c, input logic [5:0] a);
    @(posedge sys_clk);
    #2 {cke, ca_in} = {c, a};
  endtask
  // reference code with strobe edges
  task automatic strobe(input logic [6:0] v, input integer edges);
    integer i;
    @(posedge sys_clk);
    #2 dq_in[6:0] = v;
    for (i = 0; i < edges; i++) begin
      repeat (3) @(posedge sys_clk);
      #2 dqs_lower = ~dqs_lower;
    end
  endtask
endmodule
`default_nettype wire
